// ==== safe_stop_consts.svh ====
// offsets, bit positions, mode codes and reset values for the safe stop supervisor
`ifndef SAFE_STOP_CONSTS_SVH
`define SAFE_STOP_CONSTS_SVH

`define ADDR_W 8
`define OFS_CONTROL 8'h00
`define OFS_ALARM_PRIMARY 8'h04
`define OFS_ALARM_SECONDARY 8'h08
`define OFS_WARNING_PRIMARY 8'h0c
`define OFS_WARNING_SECONDARY 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_LIVE_STATUS 8'h1c

`define BIT_EVENT_FLAG 30
`define BIT_DANGER_FLAG 31
`define BIT_RESET_REQ 8

`define MODE_RESET 4'h2
`define MODE_SAFE_STOP_TRIP 4'h2
`define MODE_SAFE_STOP_WARN 4'h3
`define MODE_THERM_ONLY_TRIP 4'h4
`define MODE_THERM_ONLY_WARN 4'h5
`define MODE_COMBINED_TRIP 4'h6
`define MODE_COMBINED_WARN 4'h7
`define MODE_COMBINED_TRIP_WARN 4'h8
`define MODE_COMBINED_WARN_TRIP 4'h9

`define EV_SS_TRIP 0
`define EV_TH_TRIP 1
`define EV_DANGER 2
`define EV_SS_WARN 3
`define EV_TH_WARN 4
`define EV_COUNT 5
`define IRQ_MASK_RESET 5'h00

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== safe_stop_pkg.sv ====
// types shared by both ends of the safe stop link
package safe_stop_pkg;
	typedef logic [3:0] mode_sel_t;
	typedef logic [4:0] event_vec_t;
	typedef logic [31:0] word_t;
endpackage

// ==== card_link.sv ====
// card to drive wires: terminal 37 and the logic-out line
`timescale 1ns/1ns
`default_nettype none
interface card_link;
	logic card_safe_stop_out;
	logic card_logic_out;
	modport card (output card_safe_stop_out, output card_logic_out);
	modport drive (input card_safe_stop_out, input card_logic_out);
endinterface
`default_nettype wire

// ==== thermistor_card.sv ====
// thermistor card end: drives terminal 37 and logic-out from the relay contact
`timescale 1ns/1ns
`default_nettype none
`include "safe_stop_consts.svh"
module thermistor_card
	import safe_stop_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic thermistor_relay_contact_open,
	card_link.card link
);
	logic safe_stop_level;
	logic logic_out_level;

	// contact open: terminal 37 low and logic-out high together
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			safe_stop_level <= 1'b1;
			logic_out_level <= 1'b0;
		end else begin
			safe_stop_level <= ~thermistor_relay_contact_open;
			logic_out_level <= thermistor_relay_contact_open;
		end
	end

	assign link.card_safe_stop_out = safe_stop_level;
	assign link.card_logic_out = logic_out_level;
endmodule
`default_nettype wire

// ==== safe_stop_supervisor.sv ====
// drive side supervisor: checks card lines, raises events, holds words, axi4-lite registers
// How it works
// - bit 30 events, bit 31 dangerous failure
// - events 68/71 warn or trip, 72 lock
// - trips never cleared by automatic reset
// - safe stop trip: terminal high, then reset
// - safe stop warning clears when input released
// - thermistor trip: both lines idle, then reset
// - warning modes restart motor automatically
// - logic-out without terminal 37: dangerous, modes 4-9
// - modes 4/5: terminal without logic-out dangerous
// - modes 6-9: terminal 37 alone is legitimate
// - modes 2/3 ignore logic-out, honour terminal
// - card drives terminal low on contact open
// - logic-out input not also thermistor resource
// - on fault card lowers terminal, raises logic-out
// - combined modes accept emergency stop source
`timescale 1ns/1ns
`default_nettype none
`include "safe_stop_consts.svh"
module safe_stop_supervisor
	import safe_stop_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	card_link.drive link,
	input wire logic estop_active,
	input wire logic reset_key,
	input wire logic reset_din,
	output logic motor_run_enable,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [1:0] raw_in;
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	mode_sel_t mode;
	logic bus_reset_req;
	logic reset_req;
	logic t37_active;
	logic lo_active;
	logic therm_mode;
	logic sole_mode;
	logic ss_warn_type;
	logic th_warn_type;
	logic danger_cond;
	logic therm_cond;
	logic ss_cond;
	logic ss_trip;
	logic th_trip;
	logic danger_lock;
	logic ss_warn;
	logic th_warn;
	event_vec_t flags;
	event_vec_t flags_prev;
	event_vec_t events;
	event_vec_t irq_status;
	event_vec_t irq_mask;
	event_vec_t irq_clear;
	logic wr_fire;
	logic rd_fire;
	logic wr_hit;
	word_t next_rdata;
	logic next_rd_err;

	// two-flop synchronisers, terminal 37 idles high, logic-out idles low
	assign raw_in = {link.card_logic_out, link.card_safe_stop_out};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					sync_a[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					sync_b[gi] <= (gi == 0) ? 1'b1 : 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	// terminal 37 is active low; emergency stop is a second source
	assign t37_active = ~sync_b[0] | estop_active;
	assign lo_active = sync_b[1];

	// mode classes
	assign therm_mode = (mode >= `MODE_THERM_ONLY_TRIP) && (mode <= `MODE_COMBINED_WARN_TRIP);
	assign sole_mode = (mode == `MODE_THERM_ONLY_TRIP) || (mode == `MODE_THERM_ONLY_WARN);
	assign ss_warn_type = (mode == `MODE_SAFE_STOP_WARN) || (mode == `MODE_COMBINED_WARN)
		|| (mode == `MODE_COMBINED_TRIP_WARN);
	assign th_warn_type = (mode == `MODE_THERM_ONLY_WARN) || (mode == `MODE_COMBINED_WARN)
		|| (mode == `MODE_COMBINED_WARN_TRIP);

	// combination checks on synchronised card values and the unsynchronised emergency stop input
	always_comb begin
		danger_cond = 1'b0;
		if (therm_mode && lo_active && !t37_active) begin
			danger_cond = 1'b1;
		end
		if (sole_mode && t37_active && !lo_active) begin
			danger_cond = 1'b1;
		end
	end
	// logic-out only counts in thermistor modes, otherwise ignored
	assign therm_cond = therm_mode && lo_active && t37_active;
	// terminal 37 alone is a plain safe stop outside sole modes
	assign ss_cond = t37_active && !therm_cond && !sole_mode;

	// reset request from key, digital input or bus
	assign reset_req = reset_key | reset_din | bus_reset_req;

	// safe stop trip: needs terminal 37 released, then a reset request
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ss_trip <= 1'b0;
		end else if (ss_cond && !ss_warn_type) begin
			ss_trip <= 1'b1;
		end else if (reset_req && !t37_active) begin
			ss_trip <= 1'b0;
		end
	end

	// thermistor trip: terminal high and logic-out idle before reset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			th_trip <= 1'b0;
		end else if (therm_cond && !th_warn_type) begin
			th_trip <= 1'b1;
		end else if (reset_req && !t37_active && !lo_active) begin
			th_trip <= 1'b0;
		end
	end

	// dangerous failure is always a trip lock
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			danger_lock <= 1'b0;
		end else if (danger_cond) begin
			danger_lock <= 1'b1;
		end else if (reset_req && !t37_active && !lo_active) begin
			danger_lock <= 1'b0;
		end
	end

	// warnings follow their condition, no reset needed
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ss_warn <= 1'b0;
			th_warn <= 1'b0;
		end else begin
			ss_warn <= ss_cond && ss_warn_type;
			th_warn <= therm_cond && th_warn_type;
		end
	end

	// motor runs again once nothing holds it
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			motor_run_enable <= 1'b0;
		end else begin
			motor_run_enable <= !(t37_active || danger_cond || ss_trip || th_trip
				|| danger_lock);
		end
	end

	// sticky interrupt status, set wins over clear
	assign flags = {th_warn, ss_warn, danger_lock, th_trip, ss_trip};
	assign events = flags & ~flags_prev;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_prev <= '0;
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			flags_prev <= flags;
			irq_status <= (irq_status & ~irq_clear) | events;
			irq <= |(irq_status & irq_mask);
		end
	end

	// write channel: address and data taken together
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign wr_fire = s_axi_awready;
	assign wr_hit = (s_axi_awaddr == `OFS_CONTROL) || (s_axi_awaddr == `OFS_IRQ_STATUS)
		|| (s_axi_awaddr == `OFS_IRQ_MASK);
	assign bus_reset_req = wr_fire && (s_axi_awaddr == `OFS_CONTROL) && s_axi_wstrb[1]
		&& s_axi_wdata[`BIT_RESET_REQ];
	assign irq_clear = (wr_fire && (s_axi_awaddr == `OFS_IRQ_STATUS) && s_axi_wstrb[0])
		? s_axi_wdata[`EV_COUNT-1:0] : '0;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= `MODE_RESET;
			irq_mask <= `IRQ_MASK_RESET;
		end else if (wr_fire && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == `OFS_CONTROL) begin
				mode <= s_axi_wdata[3:0];
			end
			if (s_axi_awaddr == `OFS_IRQ_MASK) begin
				irq_mask <= s_axi_wdata[`EV_COUNT-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel and register words
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_comb begin
		next_rdata = '0;
		next_rd_err = 1'b0;
		case (s_axi_araddr)
			`OFS_CONTROL: next_rdata[3:0] = mode;
			`OFS_ALARM_PRIMARY: next_rdata[`BIT_EVENT_FLAG] = ss_trip;
			`OFS_ALARM_SECONDARY: begin
				next_rdata[`BIT_EVENT_FLAG] = th_trip;
				next_rdata[`BIT_DANGER_FLAG] = danger_lock;
			end
			`OFS_WARNING_PRIMARY: next_rdata[`BIT_EVENT_FLAG] = ss_warn;
			`OFS_WARNING_SECONDARY: next_rdata[`BIT_EVENT_FLAG] = th_warn;
			`OFS_IRQ_STATUS: next_rdata[`EV_COUNT-1:0] = irq_status;
			`OFS_IRQ_MASK: next_rdata[`EV_COUNT-1:0] = irq_mask;
			`OFS_LIVE_STATUS: next_rdata[2:0] = {motor_run_enable, lo_active, t37_active};
			default: next_rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rd_err ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== safe_stop_properties.sv ====
// assertions on the card link and the run enable
`timescale 1ns/1ns
`default_nettype none
module safe_stop_properties (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic card_safe_stop_out,
	input wire logic card_logic_out,
	input wire logic thermistor_relay_contact_open,
	input wire logic motor_run_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	stop_follows_a: assert property (thermistor_relay_contact_open |=> !card_safe_stop_out)
		else $error("terminal not low after contact open");
	stop_release_a: assert property (!thermistor_relay_contact_open |=> card_safe_stop_out)
		else $error("terminal not high after contact close");
	logic_follows_a: assert property (thermistor_relay_contact_open |=> card_logic_out)
		else $error("logic-out not raised");
	logic_release_a: assert property (!thermistor_relay_contact_open |=> !card_logic_out)
		else $error("logic-out not released");
	lines_paired_a: assert property (card_logic_out == !card_safe_stop_out)
		else $error("card lines disagree");
	logic_rise_a: assert property ($rose(card_logic_out) |-> $past(thermistor_relay_contact_open))
		else $error("logic-out rose without cause");
	run_stops_a: assert property (!card_safe_stop_out [*4] |-> !motor_run_enable)
		else $error("run enable high with terminal active");
	run_recover_a: assert property ($rose(motor_run_enable) |-> $past(card_safe_stop_out, 3))
		else $error("run enable rose with terminal active");
	cover property ($fell(card_safe_stop_out));
	cover property ($rose(card_logic_out));
	cover property ($rose(motor_run_enable));
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// bench: card and supervisor joined, plus a supervisor on a driven link
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import safe_stop_pkg::*;
;
	logic ref_clk = 0, sys_rst = 1, contact = 0, estop = 0, key = 0, din = 0, b_stop = 1, b_logic = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata_a, rdata_b;
	logic awready, wready, bvalid, arready, rvalid, run_a, irq_a;
	logic [1:0] bresp, bresp_b, rresp, nb;
	logic [65:0] n;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	int errors = 0, comparisons = 0, m, c, r;
	card_link link_a();
	card_link link_b();
	assign link_b.card_safe_stop_out = b_stop;
	assign link_b.card_logic_out = b_logic;
	thermistor_card thermistor_card_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.thermistor_relay_contact_open(contact), .link(link_a.card));
	safe_stop_supervisor safe_stop_supervisor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.link(link_a.drive), .estop_active(estop), .reset_key(key), .reset_din(din),
		.motor_run_enable(run_a), .irq(irq_a), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata_a), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	safe_stop_supervisor safe_stop_supervisor_inst_b (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.link(link_b.drive), .estop_active(1'b0), .reset_key(key), .reset_din(din),
		.motor_run_enable(), .irq(), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(), .s_axi_bresp(bresp_b), .s_axi_bvalid(), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
		.s_axi_rdata(rdata_b), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));
	safe_stop_properties safe_stop_properties_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.card_safe_stop_out(link_a.card_safe_stop_out), .card_logic_out(link_a.card_logic_out),
		.thermistor_relay_contact_open(contact), .motor_run_enable(run_a));
	initial forever #25 ref_clk = ~ref_clk;
	task automatic finish_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic wait_hi(input int s);
		logic v;
		for (int i = 0; i < 100; i++) begin
			@(negedge ref_clk);
			v = s == 0 ? awready && wready : s == 1 ? bvalid : s == 2 ? arready : rvalid;
			@(posedge ref_clk);
			if (v) return;
		end
		errors++;
		finish_test();
	endtask
	task automatic wt(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		bq.push_back(rs);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		wait_hi(0);
		awvalid <= 0;
		wvalid <= 0;
		bready <= 1;
		wait_hi(1);
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ea, input logic [31:0] eb,
		input logic [1:0] rs);
		rq.push_back({rs, ea, eb});
		araddr <= a;
		arvalid <= 1;
		wait_hi(2);
		arvalid <= 0;
		rready <= 1;
		wait_hi(3);
		rready <= 0;
	endtask
	function automatic logic [31:0] ev(input int md, input int cb, input int adr);
		logic dang, trip, warn;
		dang = cb == 0 ? md >= 4 : md inside {4, 5};
		trip = cb == 1 && md inside {2, 6, 9};
		warn = cb == 1 && md inside {3, 7, 8};
		case (adr)
			4: return trip ? 32'h40000000 : 32'h0;
			8: return dang ? 32'h80000000 : 32'h0;
			default: return warn ? 32'h40000000 : 32'h0;
		endcase
	endfunction
	always @(posedge ref_clk) begin
		if (bvalid && bready) begin
			nb = bq.pop_front();
			chk_resp(bresp, nb);
			chk_resp(bresp_b, nb);
		end
		if (rvalid && rready) begin
			n = rq.pop_front();
			chk(rdata_a, n[63:32]);
			chk(rdata_b, n[31:0]);
			chk_resp(rresp, n[65:64]);
		end
	end
	initial begin
		void'($urandom(71561));
		tick(10);
		sys_rst <= 0;
		tick(4);
		wt(8'h04, 32'h0, 2'b10);
		rd(8'hfc, 32'h0, 32'h0, 2'b10);
		for (m = 4; m < 6; m++) begin
			wt(8'h18, 32'h0, 2'b00);
			wt(8'h00, ($urandom & 32'hfffffe00) | 32'(m), 2'b00);
			contact <= 1;
			tick(8);
			chk_pin(irq_a, 1'b0);
			chk_pin(run_a, 1'b0);
			rd(m == 4 ? 8'h08 : 8'h10, 32'h40000000, 32'h0, 2'b00);
			wt(8'h18, 32'h1f, 2'b00);
			tick(2);
			chk_pin(irq_a, 1'b1);
			contact <= 0;
			tick(8);
			chk_pin(run_a, m == 5);
			rd(m == 4 ? 8'h08 : 8'h10, m == 4 ? 32'h40000000 : 32'h0, 32'h0, 2'b00);
			wt(8'h14, 32'h1f, 2'b00);
			key <= m == 4;
			tick(1);
			key <= 0;
			tick(6);
			chk_pin(irq_a, 1'b0);
			chk_pin(run_a, 1'b1);
		end
		wt(8'h00, 32'h6, 2'b00);
		estop <= 1;
		tick(6);
		rd(8'h04, 32'h40000000, 32'h0, 2'b00);
		rd(8'h08, 32'h0, 32'h0, 2'b00);
		rd(8'h1c, 32'h1, 32'h4, 2'b00);
		rd(8'h00, 32'h6, 32'h6, 2'b00);
		estop <= 0;
		// latched safe stop trip from the emergency stop needs an explicit reset
		wt(8'h00, 32'h106, 2'b00);
		rd(8'h04, 32'h0, 32'h0, 2'b00);
		chk_pin(run_a, 1'b1);
		for (c = 0; c < 2; c++)
			for (m = 2; m < 10; m++) begin
				wt(8'h00, 32'(m), 2'b00);
				b_stop <= c == 0;
				b_logic <= c == 0;
				tick(6);
				for (r = 4; r < 13; r += 4) rd(8'(r), 32'h0, ev(m, c, r), 2'b00);
				b_stop <= 1;
				b_logic <= 0;
				tick(6);
				rd(8'h0c, 32'h0, 32'h0, 2'b00);
				if (m % 3 == 2) wt(8'h00, 32'h100 | 32'(m), 2'b00);
				else begin
					key <= m % 3 == 0;
					din <= m % 3 == 1;
					tick(1);
					key <= 0;
					din <= 0;
				end
				tick(6);
				for (r = 4; r < 13; r += 4) rd(8'(r), 32'h0, 32'h0, 2'b00);
			end
		tick(2);
		finish_test();
	end
endmodule
`default_nettype wire
